// [logic/ttsr_map.vh]
// Source and destination codes, field sizes and timing counts for the trigger router.
`ifndef TTSR_MAP_VH
`define TTSR_MAP_VH
// Source codes (4 bits)
`define TTSR_SRC_NONE     4'h0
`define TTSR_SRC_LINE     4'h1
`define TTSR_SRC_FRONT0   4'h2
`define TTSR_SRC_FRONT1   4'h3
`define TTSR_SRC_STAR     4'h4
`define TTSR_SRC_REFCLK   4'h5
`define TTSR_SRC_START    4'h6
`define TTSR_SRC_COMM     4'h7
`define TTSR_SRC_CYCLE    4'h8
`define TTSR_SRC_TICK     4'h9
// Destination codes (3 bits)
`define TTSR_DST_LINE     3'h0
`define TTSR_DST_FRONT0   3'h1
`define TTSR_DST_FRONT1   3'h2
`define TTSR_DST_START    3'h3
`define TTSR_DST_TIMEBASE 3'h4
// Timebase codes
`define TTSR_TB_LOCAL     3'h0
`define TTSR_TB_LINE      3'h1
`define TTSR_TB_REFCLK    3'h2
`define TTSR_TB_TICK      3'h3
// Frequency detect codes
`define TTSR_FREQ_NONE    2'h0
`define TTSR_FREQ_1MHZ    2'h1
`define TTSR_FREQ_10MHZ   2'h2
`define TTSR_FREQ_20MHZ   2'h3
// Detection window: 10 us at 100 MHz
`define TTSR_WIN_NS       10000
`define TTSR_CLK_NS       10
`define TTSR_WIN_CYCLES   (`TTSR_WIN_NS / `TTSR_CLK_NS)
// Edge counts in the window: 1 MHz=10, 10 MHz=100, 20 MHz=200
`define TTSR_EDGES_LO     11'd5
`define TTSR_EDGES_MID    11'd50
`define TTSR_EDGES_HI     11'd150
`define TTSR_SLOT_STAR_MIN 5'd3
`endif

// [logic/ttsr_router.v]
// Trigger and timebase source router of the bus-interface card.
`timescale 1ns/1ns
`default_nettype none
`include "ttsr_map.vh"

// Functional notes
// - Any of the eight shared trigger lines, index 0 to 7, can be a routing source.
// - Either front line can be a routing source.
// - In slot 3 or above the star trigger from slot 2 can be received.
// - Star trigger and backplane clock are refused on the plug-in board variant.
// - The backplane clock goes only to the card timebase and replaces the local one.
// - Cards that must stay in step with a backplane-clocked card also use the backplane clock.
// - The start event fires on the interface start transition, one for all sessions.
// - The start event can be driven onto a shared trigger line for another card.
// - The comm running event fires on entry to running, one for all sessions.
// - The comm running event serves as start indication when bus time tick is exported.
// - The cycle begin source gives one pulse per bus cycle.
// - Cycle begin and bus time tick exist only on variants with the bus interface.
// - The tick routes to trigger or front lines and toggles only while communicating.
// - Tick as timebase clocks the timestamp counter in bus time and exposes the tick count within the bus cycle.
// - An external start source starts the interface on its first rising edge.
// - The timebase input detects 1, 10 or 20 MHz without configuration.
module ttsr_router #(
  parameter IS_BACKPLANE = 1,
  parameter HAS_BUS_IF   = 1,
  parameter TS_WIDTH     = 32,
  parameter MT_WIDTH     = 16
) (
  input  wire                sys_clk,
  input  wire                rst_b,
  input  wire                cfgValid,
  input  wire [3:0]          cfgSource,
  input  wire [2:0]          cfgSourceLine,
  input  wire [2:0]          cfgDest,
  input  wire [2:0]          cfgDestLine,
  input  wire                cfgConnect,
  input  wire [4:0]          slotNumber,
  input  wire [7:0]          shared_trigger_line_n_in,
  input  wire                front_line_zero_in,
  input  wire                front_line_one_in,
  input  wire                slot_star_trigger,
  input  wire                backplane_ref_clock,
  input  wire                interface_start_event,
  input  wire                comm_running_event,
  input  wire                busCommunicating,
  input  wire                bus_cycle_begin_pulse,
  input  wire                bus_time_tick,
  input  wire                localTimebase,
  output reg                 cfgAck,
  output reg                 cfgReject,
  output reg  [7:0]          shared_trigger_line_n_out,
  output reg  [7:0]          shared_trigger_line_n_oe,
  output reg                 front_line_zero_out,
  output reg                 front_line_zero_oe,
  output reg                 front_line_one_out,
  output reg                 front_line_one_oe,
  output reg                 startInterface,
  output reg                 card_timebase_input,
  output reg  [2:0]          timebaseSel,
  output reg  [1:0]          timebaseFreq,
  output reg  [TS_WIDTH-1:0] timestampCount,
  output reg  [MT_WIDTH-1:0] cycleTickCount
);

  localparam [TS_WIDTH-1:0] TS_ONE     = {{(TS_WIDTH-1){1'b0}}, 1'b1};
  localparam [MT_WIDTH-1:0] MT_ONE     = {{(MT_WIDTH-1){1'b0}}, 1'b1};
  localparam integer        WIN_LAST_I = `TTSR_WIN_CYCLES - 1;
  localparam [10:0]         WIN_LAST   = WIN_LAST_I[10:0];

  ////////////////////////////////////////////////////////////////////////////
  // Pairing check
  function legalPair;
    input [3:0] src;
    input [2:0] dst;
    input [4:0] slot;
    reg         outDst;
    begin
      outDst = (dst == `TTSR_DST_LINE) || (dst == `TTSR_DST_FRONT0) || (dst == `TTSR_DST_FRONT1);
      case (src)
        `TTSR_SRC_LINE, `TTSR_SRC_FRONT0, `TTSR_SRC_FRONT1:
          legalPair = (dst == `TTSR_DST_START) || (dst == `TTSR_DST_TIMEBASE);
        `TTSR_SRC_STAR:
          legalPair = (IS_BACKPLANE != 0) && (slot >= `TTSR_SLOT_STAR_MIN)
                      && (dst == `TTSR_DST_START);
        `TTSR_SRC_REFCLK:
          legalPair = (IS_BACKPLANE != 0) && (dst == `TTSR_DST_TIMEBASE);
        `TTSR_SRC_START, `TTSR_SRC_COMM:
          legalPair = outDst;
        `TTSR_SRC_CYCLE:
          legalPair = (HAS_BUS_IF != 0) && outDst;
        `TTSR_SRC_TICK:
          legalPair = (HAS_BUS_IF != 0) && (outDst || (dst == `TTSR_DST_TIMEBASE));
        default:
          legalPair = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Route tables
  reg [3:0] lineSrc [0:7];
  reg [3:0] front0Src;
  reg [3:0] front1Src;
  reg [3:0] startSrc;
  reg [2:0] startLine;
  reg [2:0] tbLine;
  reg [3:0] tbSrc;
  reg [2:0] lineSrcIdx [0:7];
  reg [2:0] front0Idx;
  reg [2:0] front1Idx;
  integer   i;
  integer   j;

  wire cfgLegal = legalPair(cfgSource, cfgDest, slotNumber);

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < 8; i = i + 1) begin
        lineSrc[i]    <= `TTSR_SRC_NONE;
        lineSrcIdx[i] <= 3'h0;
      end
      front0Src <= `TTSR_SRC_NONE;
      front1Src <= `TTSR_SRC_NONE;
      front0Idx <= 3'h0;
      front1Idx <= 3'h0;
      startSrc  <= `TTSR_SRC_NONE;
      startLine <= 3'h0;
      tbSrc     <= `TTSR_SRC_NONE;
      tbLine    <= 3'h0;
      cfgAck    <= 1'b0;
      cfgReject <= 1'b0;
    end else begin
      cfgAck    <= cfgValid && cfgLegal;
      cfgReject <= cfgValid && !cfgLegal;
      if (cfgValid && cfgLegal) begin
        case (cfgDest)
          `TTSR_DST_LINE: begin
            lineSrc[cfgDestLine]    <= cfgConnect ? cfgSource : `TTSR_SRC_NONE;
            lineSrcIdx[cfgDestLine] <= cfgSourceLine;
          end
          `TTSR_DST_FRONT0: begin
            front0Src <= cfgConnect ? cfgSource : `TTSR_SRC_NONE;
            front0Idx <= cfgSourceLine;
          end
          `TTSR_DST_FRONT1: begin
            front1Src <= cfgConnect ? cfgSource : `TTSR_SRC_NONE;
            front1Idx <= cfgSourceLine;
          end
          `TTSR_DST_START: begin
            startSrc  <= cfgConnect ? cfgSource : `TTSR_SRC_NONE;
            startLine <= cfgSourceLine;
          end
          `TTSR_DST_TIMEBASE: begin
            tbSrc  <= cfgConnect ? cfgSource : `TTSR_SRC_NONE;
            tbLine <= cfgSourceLine;
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal source values
  function srcValue;
    input [3:0] src;
    input [2:0] idx;
    input [7:0] lines;
    input       f0;
    input       f1;
    input       star;
    input       startEv;
    input       commEv;
    input       cyc;
    input       tick;
    begin
      case (src)
        `TTSR_SRC_LINE:   srcValue = lines[idx];
        `TTSR_SRC_FRONT0: srcValue = f0;
        `TTSR_SRC_FRONT1: srcValue = f1;
        `TTSR_SRC_STAR:   srcValue = star;
        `TTSR_SRC_START:  srcValue = startEv;
        `TTSR_SRC_COMM:   srcValue = commEv;
        `TTSR_SRC_CYCLE:  srcValue = cyc;
        `TTSR_SRC_TICK:   srcValue = tick;
        default:          srcValue = 1'b0;
      endcase
    end
  endfunction

  // Tick is gated so no edges leak before bus integration
  wire gatedTick = bus_time_tick && busCommunicating && (HAS_BUS_IF != 0);
  wire cycPulse  = bus_cycle_begin_pulse && (HAS_BUS_IF != 0);

  ////////////////////////////////////////////////////////////////////////////
  // Output drivers
  reg startSeen;
  reg startPrev;
  wire startRaw = srcValue(startSrc, startLine, shared_trigger_line_n_in, front_line_zero_in,
                           front_line_one_in, slot_star_trigger, 1'b0, 1'b0, 1'b0, 1'b0);
  wire startEdge = startRaw && !startPrev && !startSeen && (startSrc != `TTSR_SRC_NONE);

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shared_trigger_line_n_out <= 8'h00;
      shared_trigger_line_n_oe  <= 8'h00;
      front_line_zero_out       <= 1'b0;
      front_line_zero_oe        <= 1'b0;
      front_line_one_out        <= 1'b0;
      front_line_one_oe         <= 1'b0;
      startInterface            <= 1'b0;
      startSeen                 <= 1'b0;
      startPrev                 <= 1'b1;
    end else begin
      for (j = 0; j < 8; j = j + 1) begin
        shared_trigger_line_n_oe[j]  <= lineSrc[j] != `TTSR_SRC_NONE;
        shared_trigger_line_n_out[j] <= srcValue(lineSrc[j], lineSrcIdx[j], shared_trigger_line_n_in,
          front_line_zero_in, front_line_one_in, slot_star_trigger, interface_start_event,
          comm_running_event, cycPulse, gatedTick);
      end
      front_line_zero_oe  <= front0Src != `TTSR_SRC_NONE;
      front_line_zero_out <= srcValue(front0Src, front0Idx, shared_trigger_line_n_in, front_line_zero_in,
        front_line_one_in, slot_star_trigger, interface_start_event, comm_running_event, cycPulse,
        gatedTick);
      front_line_one_oe   <= front1Src != `TTSR_SRC_NONE;
      front_line_one_out  <= srcValue(front1Src, front1Idx, shared_trigger_line_n_in, front_line_zero_in,
        front_line_one_in, slot_star_trigger, interface_start_event, comm_running_event, cycPulse,
        gatedTick);
      // Only the first rising edge starts; a re-route rearms
      startPrev <= (startSrc == `TTSR_SRC_NONE) ? 1'b1 : startRaw;
      if (cfgValid && cfgLegal && cfgDest == `TTSR_DST_START)
        startSeen <= 1'b0;
      else if (startEdge)
        startSeen <= 1'b1;
      startInterface <= startEdge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timebase select, frequency detect, bus-time counters
  wire tbRaw = (tbSrc == `TTSR_SRC_REFCLK) ? backplane_ref_clock :
               (tbSrc == `TTSR_SRC_TICK)   ? gatedTick :
               (tbSrc == `TTSR_SRC_NONE)   ? localTimebase :
               srcValue(tbSrc, tbLine, shared_trigger_line_n_in, front_line_zero_in, front_line_one_in,
                        1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
  reg        tbPrev;
  reg [10:0] winCount;
  reg [10:0] edgeCount;
  wire       tbEdge = tbRaw && !tbPrev;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tbPrev              <= 1'b0;
      card_timebase_input <= 1'b0;
      timebaseSel         <= `TTSR_TB_LOCAL;
      timebaseFreq        <= `TTSR_FREQ_NONE;
      winCount            <= 11'h000;
      edgeCount           <= 11'h000;
      timestampCount      <= {TS_WIDTH{1'b0}};
      cycleTickCount      <= {MT_WIDTH{1'b0}};
    end else begin
      tbPrev              <= tbRaw;
      card_timebase_input <= tbRaw;
      timebaseSel <= (tbSrc == `TTSR_SRC_REFCLK) ? `TTSR_TB_REFCLK :
                     (tbSrc == `TTSR_SRC_TICK)   ? `TTSR_TB_TICK :
                     (tbSrc == `TTSR_SRC_NONE)   ? `TTSR_TB_LOCAL : `TTSR_TB_LINE;
      if (winCount == WIN_LAST) begin
        winCount  <= 11'h000;
        edgeCount <= 11'h000;
        if (edgeCount >= `TTSR_EDGES_HI)
          timebaseFreq <= `TTSR_FREQ_20MHZ;
        else if (edgeCount >= `TTSR_EDGES_MID)
          timebaseFreq <= `TTSR_FREQ_10MHZ;
        else if (edgeCount >= `TTSR_EDGES_LO)
          timebaseFreq <= `TTSR_FREQ_1MHZ;
        else
          timebaseFreq <= `TTSR_FREQ_NONE;
      end else begin
        winCount <= winCount + 11'h001;
        if (tbEdge)
          edgeCount <= edgeCount + 11'h001;
      end
      if (tbEdge)
        timestampCount <= timestampCount + TS_ONE;
      if (tbSrc == `TTSR_SRC_TICK && cycPulse)
        cycleTickCount <= {MT_WIDTH{1'b0}};
      else if (tbSrc == `TTSR_SRC_TICK && tbEdge)
        cycleTickCount <= cycleTickCount + MT_ONE;
    end
  end

endmodule // ttsr_router
`default_nettype wire

// [verif/ttsr_router_checker.sv]
// Port checks for the trigger router.
`timescale 1ns/1ns
`default_nettype none
`include "ttsr_map.vh"
module ttsr_router_checker (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       cfgValid,
  input wire logic [3:0] cfgSource,
  input wire logic [2:0] cfgDest,
  input wire logic       cfgConnect,
  input wire logic [4:0] slotNumber,
  input wire logic       cfgAck,
  input wire logic       cfgReject,
  input wire logic [7:0] shared_trigger_line_n_oe,
  input wire logic       front_line_zero_oe,
  input wire logic       front_line_one_oe,
  input wire logic       startInterface
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic routed;
  wire  req    = cfgValid && cfgConnect;
  wire  extSrc = cfgSource inside {[`TTSR_SRC_LINE:`TTSR_SRC_FRONT1]};
  wire  toPin  = cfgDest <= `TTSR_DST_FRONT1;
  ////////////////////////////////////////////////////////////
  // Nothing may drive a pin before the first accepted request
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) routed <= 1'b0;
    else if (cfgAck) routed <= 1'b1;
  ////////////////////////////////////////////////////////////
  chk_cfg_answer: assert property (cfgValid |=> cfgAck != cfgReject) else $error("no answer");
  chk_no_stray: assert property (!cfgValid |=> !cfgAck && !cfgReject) else $error("stray answer");
  chk_star_slot: assert property (req && cfgSource == `TTSR_SRC_STAR &&
    slotNumber < `TTSR_SLOT_STAR_MIN |=> cfgReject) else $error("star taken below slot");
  chk_refclk_dest: assert property (req && cfgSource == `TTSR_SRC_REFCLK &&
    cfgDest != `TTSR_DST_TIMEBASE |=> cfgReject) else $error("refclk off timebase");
  chk_event_pin: assert property (req && cfgSource inside {`TTSR_SRC_START, `TTSR_SRC_COMM} &&
    !toPin |=> cfgReject) else $error("event off pins");
  chk_ext_pin: assert property (req && extSrc && toPin |=> cfgReject) else $error("pin to pin");
  chk_tick_start: assert property (req && cfgSource == `TTSR_SRC_TICK &&
    cfgDest == `TTSR_DST_START |=> cfgReject) else $error("tick to start");
  chk_start_once: assert property (startInterface |=> !startInterface) else $error("long start");
  chk_idle_oe: assert property (!routed |-> shared_trigger_line_n_oe == 8'h00 &&
    !front_line_zero_oe && !front_line_one_oe) else $error("pin driven unrouted");
  cover property (cfgAck);
  cover property (cfgReject);
  cover property (startInterface);
endmodule // ttsr_router_checker
bind ttsr_router ttsr_router_checker ttsr_router_checker_inst (.sys_clk, .rst_b, .cfgValid, .cfgSource,
  .cfgDest, .cfgConnect, .slotNumber, .cfgAck, .cfgReject, .shared_trigger_line_n_oe, .front_line_zero_oe,
  .front_line_one_oe, .startInterface);
`default_nettype wire

// [verif/ttsr_peer_card.sv]
// Peer card model on the eight shared trigger lines.
`timescale 1ns/1ns
`default_nettype none
module ttsr_peer_card (
  input  wire logic [7:0] routerOut,
  input  wire logic [7:0] routerOe,
  input  wire logic [7:0] driveEn,
  input  wire logic [7:0] driveVal,
  input  wire logic [7:0] clkPeriod,
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  output var  logic [7:0] lineLevel,
  output var  logic [7:0] startCount
);
  logic [7:0] phase;
  logic [7:0] noise;
  logic       lastLvl;
  wire        clkLvl = phase < clkPeriod / 8'd2;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {phase, noise, lastLvl, startCount} <= {8'h00, 8'h55, 1'b0, 8'h00};
    end else begin
      phase <= phase + 8'h01 >= clkPeriod ? 8'h00 : phase + 8'h01;
      // Released lines wander so a stale level never passes for a driven one
      noise <= ~noise;
      lastLvl <= lineLevel[7];
      if (lineLevel[7] && !lastLvl) startCount <= startCount + 8'h01;
    end
  end
  // Line 0 carries a peer timebase of clkPeriod cycles when nonzero
  always_comb
    for (int i = 0; i < 8; i++)
      lineLevel[i] = routerOe[i] ? routerOut[i] : !driveEn[i] ? noise[i] :
                     (i == 0 && clkPeriod != 8'h00) ? clkLvl : driveVal[i];
endmodule // ttsr_peer_card
`default_nettype wire

// [verif/ttsr_router_bench.sv]
// Self-checking bench for the trigger router beside a peer card.
`timescale 1ns/1ns
`default_nettype none
`include "ttsr_map.vh"
module ttsr_router_bench;
  logic        sys_clk, rst_b, cfgValid, cfgConnect, cfgAck, cfgReject, startInterface, card_timebase_input, tickRun;
  logic [3:0]  cfgSource;
  logic [2:0]  cfgSourceLine, cfgDest, cfgDestLine, timebaseSel;
  logic [4:0]  slotNumber;
  logic [7:0]  shared_trigger_line_n_in, shared_trigger_line_n_out, shared_trigger_line_n_oe;
  logic [7:0]  driveEn, driveVal, clkPeriod, startCount;
  logic        front_line_zero_in, front_line_one_in, front_line_zero_out, front_line_zero_oe, front_line_one_out;
  logic        front_line_one_oe, slot_star_trigger, backplane_ref_clock, interface_start_event, comm_running_event;
  logic        busCommunicating, bus_cycle_begin_pulse, bus_time_tick;
  logic [1:0]  timebaseFreq;
  logic [31:0] timestampCount;
  logic [15:0] cycleTickCount;
  wire         localTimebase = ~backplane_ref_clock;
  int          n_errors = 0, n_checks = 0, refCnt = 0;
  ttsr_router ttsr_router_inst (.sys_clk, .rst_b, .cfgValid, .cfgSource, .cfgSourceLine, .cfgDest, .cfgDestLine,
    .cfgConnect, .slotNumber, .shared_trigger_line_n_in, .front_line_zero_in, .front_line_one_in, .slot_star_trigger,
    .backplane_ref_clock, .interface_start_event, .comm_running_event, .busCommunicating, .bus_cycle_begin_pulse,
    .bus_time_tick, .localTimebase, .cfgAck, .cfgReject, .shared_trigger_line_n_out, .shared_trigger_line_n_oe,
    .front_line_zero_out, .front_line_zero_oe, .front_line_one_out, .front_line_one_oe, .startInterface,
    .card_timebase_input, .timebaseSel, .timebaseFreq, .timestampCount, .cycleTickCount);
  ttsr_peer_card ttsr_peer_card_inst (.sys_clk, .rst_b, .routerOut(shared_trigger_line_n_out),
    .routerOe(shared_trigger_line_n_oe), .driveEn, .driveVal, .clkPeriod, .lineLevel(shared_trigger_line_n_in),
    .startCount);
  ////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // One 10 MHz reference shared by every card kept in step
  always @(negedge sys_clk) begin
    refCnt <= refCnt == 4 ? 0 : refCnt + 1;
    if (refCnt == 4) backplane_ref_clock <= ~backplane_ref_clock;
    if (tickRun) bus_time_tick <= ~bus_time_tick;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic route(input logic [3:0] s, input logic [2:0] sl, d, dl, input logic c, ok);
    {cfgSource, cfgSourceLine, cfgDest, cfgDestLine, cfgConnect, cfgValid} = {s, sl, d, dl, c, 1'b1};
    @(negedge sys_clk);
    // Answer stands for one cycle only
    check("cfgAck", cfgAck, ok);
    check("cfgReject", cfgReject, !ok);
    cfgValid = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_events();
    logic [7:0] c0;
    int hits = 0;
    route(`TTSR_SRC_START, 3'h0, `TTSR_DST_LINE, 3'h7, 1'b1, 1'b1);
    route(`TTSR_SRC_COMM, 3'h0, `TTSR_DST_FRONT0, 3'h0, 1'b1, 1'b1);
    check("frontOe", front_line_zero_oe, 1'b1);
    c0 = startCount;
    {interface_start_event, comm_running_event} = 2'b11;
    @(negedge sys_clk);
    {interface_start_event, comm_running_event} = 2'b00;
    repeat (4) begin
      hits += front_line_zero_out;
      @(negedge sys_clk);
    end
    check("commOut", hits, 1);
    check("peerStarts", startCount - c0, 1);
    route(`TTSR_SRC_START, 3'h0, `TTSR_DST_LINE, 3'h7, 1'b0, 1'b1);
    check("lineOe", shared_trigger_line_n_oe, 8'h00);
  endtask
  task automatic t_start_in();
    logic [3:0] src [3] = '{`TTSR_SRC_LINE, `TTSR_SRC_FRONT1, `TTSR_SRC_STAR};
    int hits;
    for (int k = 0; k < 3; k++) begin
      route(src[k], 3'h3, `TTSR_DST_START, 3'h0, 1'b1, 1'b1);
      hits = 0;
      for (int i = 0; i < 40; i++) begin
        {driveVal[3], front_line_one_in, slot_star_trigger, front_line_zero_in} = {4{i % 10 >= 5}};
        hits += startInterface;
        @(negedge sys_clk);
      end
      check("startPulses", hits, 1);
    end
  endtask
  task automatic t_reject();
    logic [11:0] t [6] = '{{`TTSR_SRC_STAR, `TTSR_DST_START, 5'd2}, {`TTSR_SRC_REFCLK, `TTSR_DST_LINE, 5'd3},
      {`TTSR_SRC_START, `TTSR_DST_START, 5'd3}, {`TTSR_SRC_COMM, `TTSR_DST_TIMEBASE, 5'd3},
      {`TTSR_SRC_FRONT0, `TTSR_DST_LINE, 5'd3}, {`TTSR_SRC_TICK, `TTSR_DST_START, 5'd3}};
    for (int i = 0; i < 6; i++) begin
      slotNumber = t[i][4:0];
      route(t[i][11:8], 3'h2, t[i][7:5], 3'h2, 1'b1, 1'b0);
    end
    slotNumber = 5'd3;
  endtask
  task automatic t_tick();
    logic prev;
    int hits;
    route(`TTSR_SRC_TICK, 3'h0, `TTSR_DST_FRONT1, 3'h0, 1'b1, 1'b1);
    route(`TTSR_SRC_CYCLE, 3'h0, `TTSR_DST_LINE, 3'h1, 1'b1, 1'b1);
    tickRun = 1'b1;
    for (int k = 0; k < 2; k++) begin
      {busCommunicating, hits, prev} = {k[0], 32'd0, front_line_one_out};
      repeat (20) begin
        @(negedge sys_clk);
        hits += front_line_one_out !== prev;
        prev = front_line_one_out;
      end
      check("tickEdges", k ? 32'(hits > 15) : hits, k);
    end
    {hits, bus_cycle_begin_pulse} = {32'd0, 1'b1};
    @(negedge sys_clk);
    bus_cycle_begin_pulse = 1'b0;
    repeat (5) begin
      hits += shared_trigger_line_n_out[1];
      @(negedge sys_clk);
    end
    check("cyclePulse", hits, 1);
  endtask
  task automatic t_timebase();
    logic [7:0] per [3] = '{8'd100, 8'd10, 8'd5};
    logic [31:0] ts;
    int hits;
    route(`TTSR_SRC_LINE, 3'h0, `TTSR_DST_TIMEBASE, 3'h0, 1'b1, 1'b1);
    check("tbSel", timebaseSel, `TTSR_TB_LINE);
    for (int i = 0; i < 3; i++) begin
      clkPeriod = per[i];
      repeat (2100) @(negedge sys_clk);
      check("tbFreq", timebaseFreq, i + 1);
    end
    route(`TTSR_SRC_TICK, 3'h0, `TTSR_DST_TIMEBASE, 3'h0, 1'b1, 1'b1);
    ts = timestampCount;
    repeat (100) @(negedge sys_clk);
    check("tbSel", timebaseSel, `TTSR_TB_TICK);
    check("tsCount", timestampCount - ts, 50);
    bus_cycle_begin_pulse = 1'b1;
    @(negedge sys_clk);
    bus_cycle_begin_pulse = 1'b0;
    repeat (20) @(negedge sys_clk);
    check("cycTicks", cycleTickCount, 10);
    route(`TTSR_SRC_REFCLK, 3'h0, `TTSR_DST_TIMEBASE, 3'h0, 1'b1, 1'b1);
    repeat (2100) @(negedge sys_clk);
    check("tbSel", timebaseSel, `TTSR_TB_REFCLK);
    check("tbFreq", timebaseFreq, `TTSR_FREQ_10MHZ);
    // Local timebase is the inverse, so a wrong pick shows here
    hits = 0;
    repeat (20) begin
      @(negedge sys_clk);
      hits += card_timebase_input !== backplane_ref_clock;
    end
    check("tbFollow", hits, 0);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {cfgValid, cfgConnect, cfgSource, cfgSourceLine, cfgDest, cfgDestLine, tickRun} = '0;
    {front_line_zero_in, front_line_one_in, slot_star_trigger, backplane_ref_clock, bus_time_tick} = '0;
    {interface_start_event, comm_running_event, busCommunicating, bus_cycle_begin_pulse} = '0;
    {driveEn, driveVal, clkPeriod, slotNumber, rst_b} = {8'h09, 8'h00, 8'h00, 5'd3, 1'b0};
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    t_events();
    t_start_in();
    t_reject();
    t_tick();
    t_timebase();
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    finish_test();
  end
endmodule // ttsr_router_bench
`default_nettype wire
